//--- hdl/mls_modem_line_status.sv
/*
 * Modem control, line status, modem status and scratch registers of one
 * serial channel, with the prescaler enable and receive-store gating.
 * Assumes the receiver, transmitter and FIFOs run on i_ref_clk and present
 * their events as one-cycle pulses; modem pins are asynchronous.
 */
module mls_modem_line_status
    import mls_pkg::*;
(
    input  wire logic       i_ref_clk,        // 40 MHz register clock
    input  wire logic       i_reset,          // Async reset, active high
    input  wire logic [2:0] i_addr,           // Register index
    input  wire logic [7:0] i_wdata,          // Write data
    input  wire logic       i_wr,             // Write strobe
    input  wire logic       i_rd,             // Read strobe
    output logic      [7:0] o_rdata,          // Read data, cycle after strobe
    input  wire logic       i_cts_n,          // Clear-to-send pin
    input  wire logic       i_dsr_n,          // Data-set-ready pin
    input  wire logic       i_ring_indicate_in_n,  // Ring pin
    input  wire logic       i_carrier_detect_in_n, // Carrier pin
    output logic            o_dtr_n,          // Terminal-ready pin
    output logic            o_rts_n,          // Request-to-send pin
    output logic            o_spare_output_n, // Spare output pin
    output logic            o_int_oe_n,       // Interrupt pin enable, low drives
    output logic            o_modem_irq,      // Modem-status interrupt request
    output logic            o_loopback,       // Loopback routing select
    output logic            o_irda_sel,       // Infrared routing select
    input  wire logic       i_tx_serial,      // Plain transmit bit
    input  wire logic       i_tx_ir,          // Infrared encoder output
    output logic            o_tx_line,        // Transmit pin level
    output logic            o_baud_en,        // Baud generator input enable
    input  wire logic       i_rx_done,        // Receiver completed a character
    input  wire logic       i_rx_parity_err,  // Tag of completed character
    input  wire logic       i_rx_frame_err,   // Tag of completed character
    input  wire logic       i_rx_break,       // Completed frame was a break
    input  wire logic       i_rx_flow_char,   // Completed char is Xon or Xoff
    input  wire logic       i_sw_flow_on,     // Software flow control active
    input  wire logic       i_rx_fifo_full,   // Receive FIFO full
    input  wire logic [6:0] i_rx_fifo_count,  // Receive FIFO level
    input  wire logic       i_rhr_load,       // Next character reaches holding
    input  wire logic [2:0] i_rhr_tags,       // Its break, framing, parity tags
    input  wire logic       i_rhr_read,       // Host took the holding character
    input  wire logic       i_tx_fifo_empty,  // Transmit holding/FIFO empty
    input  wire logic       i_tsr_empty,      // Transmit shifter empty
    input  wire logic       i_auto_cts_en,    // Auto clear-to-send enabled
    input  wire logic [7:0] i_fifo_level,     // Level counter value for swap
    output logic            o_fifo_push,      // Store character into FIFO
    output logic            o_tx_resume,      // Xon-any resume pulse
    output logic            o_tx_halt,        // Stop after current character
    output logic      [7:0] o_mode_select     // Enhanced mode select register
);

    // Whole state of the block
    typedef struct packed {
        logic [7:0] modem_control;        // Modem control
        logic [7:0] scr;        // Scratch
        logic [7:0] interrupt_enable;        // Interrupt enable
        logic [7:0] feature_control;       // Feature control
        logic [7:0] enhanced_mode_select;       // Enhanced mode select
        logic [3:0] sync1;      // First synchroniser stage
        logic [3:0] sync2;      // Second synchroniser stage
        logic [3:0] prev;       // Previous effective modem levels
        logic [3:0] delta;      // Change bits
        logic       overrun;    // Sticky overrun
        logic       brk;        // Sticky break
        logic       brk_block;  // Last completed character was a break
        logic [2:0] head;       // Tags of holding character
        logic [6:0] err_cnt;    // Errored characters in FIFO
        logic [7:0] rdata;      // Read data
        logic       dtr_n;
        logic       rts_n;
        logic       spare_n;
        logic       int_oe_n;
        logic       irq;
        logic       txl;
        logic [1:0] presc;      // Prescaler count
        logic       baud_en;
        logic       push;
        logic       resume;
        logic       halt;
    } mls_state_s;

    mls_state_s st;       // Registered state
    mls_state_s next_st;  // Next state

    logic [3:0] eff_lvl;  // Effective active-high modem levels
    logic [7:0] lsr_val;  // Line status as read
    logic [7:0] msr_val;  // Modem status as read
    logic       rd_lsr;   // Line status read strobe
    logic       rd_msr;   // Modem status read strobe
    logic       store;    // Completed character is kept
    logic       rx_err;   // Completed character carries a tag

    // Effective modem levels: pins or loopback of control bits
    always_comb
    begin
        if (st.modem_control[MC_LOOP])
        begin
            // Bits from the top: carrier, ring, dsr, cts
            eff_lvl = {st.modem_control[MC_INT_EN], st.modem_control[MC_SPARE1],
                       st.modem_control[MC_READY], st.modem_control[MC_REQUEST]}; // RULE_20
        end
        else
        begin
            eff_lvl = ~st.sync2; // RULE_19
        end
    end

    // Read values of the status registers
    always_comb
    begin
        msr_val = {eff_lvl[3], eff_lvl[2], eff_lvl[1], eff_lvl[0], st.delta};
        lsr_val = {(st.err_cnt != 7'h00),                          // RULE_15
                   (i_tx_fifo_empty && i_tsr_empty),               // RULE_14
                   i_tx_fifo_empty,                                // RULE_13
                   (st.head[2] | st.brk),                          // RULE_12
                   st.head[1:0],                                   // RULE_11
                   st.overrun,
                   (i_rx_fifo_count != 7'h00)};                    // RULE_09
        rd_lsr  = i_rd && (i_addr == ADDR_LINE_STATUS);
        rd_msr  = i_rd && (i_addr == ADDR_MODEM_STATUS);
        rx_err  = i_rx_parity_err | i_rx_frame_err | i_rx_break;
        // Drop on full FIFO, repeated break, or flow char under Xon-any
        store   = i_rx_done && !i_rx_fifo_full                     // RULE_10
                  && !(i_rx_break && st.brk_block)                 // RULE_12
                  && !(st.modem_control[MC_XON_ANY] && i_sw_flow_on && i_rx_flow_char); // RULE_06
    end

    // Next-state logic
    always_comb
    begin
        next_st = st;
        // Synchronise modem pins
        next_st.sync1 = {i_carrier_detect_in_n, i_ring_indicate_in_n, i_dsr_n, i_cts_n};
        next_st.sync2 = st.sync1;
        next_st.prev  = eff_lvl;
        // Register writes
        if (i_wr)
        begin
            case (i_addr)
                ADDR_MODEM_CONTROL: next_st.modem_control  = i_wdata;
                ADDR_INT_ENABLE:    next_st.interrupt_enable  = i_wdata;
                ADDR_FEATURE_CTRL:  next_st.feature_control = i_wdata;
                ADDR_SCRATCH:
                begin
                    if (st.feature_control[FC_SWAP])
                    begin
                        next_st.enhanced_mode_select = i_wdata; // RULE_22
                    end
                    else
                    begin
                        next_st.scr = i_wdata;
                    end
                end
                default: ;
            endcase
        end
        // Read data, zero for unmapped
        next_st.rdata = 8'h00;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_MODEM_CONTROL: next_st.rdata = st.modem_control;
                ADDR_INT_ENABLE:    next_st.rdata = st.interrupt_enable;
                ADDR_FEATURE_CTRL:  next_st.rdata = st.feature_control;
                ADDR_LINE_STATUS:   next_st.rdata = lsr_val;
                ADDR_MODEM_STATUS:  next_st.rdata = msr_val;
                ADDR_SCRATCH:       next_st.rdata = st.feature_control[FC_SWAP] ? i_fifo_level // RULE_23
                                                                     : st.scr;
                default:            next_st.rdata = 8'h00;
            endcase
        end
        // Delta bits: read clears, new change wins
        if (rd_msr)
        begin
            next_st.delta = 4'h0; // RULE_24
        end
        next_st.delta[0] = next_st.delta[0] | (eff_lvl[0] ^ st.prev[0]); // RULE_16
        next_st.delta[1] = next_st.delta[1] | (eff_lvl[1] ^ st.prev[1]); // RULE_16
        next_st.delta[2] = next_st.delta[2] | (!eff_lvl[2] && st.prev[2]); // RULE_17
        next_st.delta[3] = next_st.delta[3] | (eff_lvl[3] ^ st.prev[3]); // RULE_16
        next_st.irq = st.interrupt_enable[IE_MODEM] && (next_st.delta != 4'h0); // RULE_16
        // Sticky overrun and break: read clears, new event wins
        if (rd_lsr)
        begin
            next_st.overrun = 1'b0; // RULE_25
            next_st.brk     = 1'b0; // RULE_25
        end
        if (i_rx_done && i_rx_fifo_full)
        begin
            next_st.overrun = 1'b1; // RULE_10
        end
        if (i_rx_done && i_rx_break)
        begin
            next_st.brk       = 1'b1;
            next_st.brk_block = 1'b1; // RULE_12
        end
        else if (i_rx_done)
        begin
            next_st.brk_block = 1'b0;
        end
        // Holding character tags
        if (i_rhr_load)
        begin
            next_st.head = i_rhr_tags; // RULE_11
        end
        // Count of errored characters in FIFO
        if ((store && rx_err) && !(i_rhr_read && (st.head != 3'h0)))
        begin
            next_st.err_cnt = st.err_cnt + 7'h01; // RULE_15
        end
        else if (!(store && rx_err) && i_rhr_read && (st.head != 3'h0)
                 && (st.err_cnt != 7'h00))
        begin
            next_st.err_cnt = st.err_cnt - 7'h01; // RULE_15
        end
        next_st.push   = store;
        next_st.resume = i_rx_done && st.modem_control[MC_XON_ANY]; // RULE_05
        // Auto clear-to-send: high pin stops transmitter
        next_st.halt   = i_auto_cts_en && !eff_lvl[0]; // RULE_18
        // Pins from control bits
        next_st.dtr_n    = !next_st.modem_control[MC_READY];   // RULE_01
        next_st.rts_n    = !next_st.modem_control[MC_REQUEST]; // RULE_01
        next_st.spare_n  = !next_st.modem_control[MC_INT_EN];  // RULE_02
        next_st.int_oe_n = !next_st.modem_control[MC_INT_EN];  // RULE_02
        // Transmit pin: infrared idles low, loopback holds mark
        if (st.modem_control[MC_LOOP])
        begin
            next_st.txl = 1'b1; // RULE_04
        end
        else if (st.modem_control[MC_IRDA])
        begin
            next_st.txl = i_tx_ir; // RULE_07
        end
        else
        begin
            next_st.txl = i_tx_serial;
        end
        // Prescaler: every cycle or every fourth cycle
        if (st.modem_control[MC_PRESCALE])
        begin
            next_st.presc   = st.presc + 2'h1;
            next_st.baud_en = (st.presc == PRESCALE_LAST); // RULE_08
        end
        else
        begin
            next_st.presc   = 2'h0;
            next_st.baud_en = 1'b1; // RULE_08
        end
    end

    // State register
    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st           <= '0;
            st.modem_control       <= MODEM_CONTROL_RST; // RULE_04
            st.scr       <= SCRATCH_RST;       // RULE_21
            st.interrupt_enable       <= INT_ENABLE_RST;
            st.feature_control      <= FEATURE_CTRL_RST;
            st.enhanced_mode_select      <= MODE_SELECT_RST;
            st.sync1     <= 4'hf;
            st.sync2     <= 4'hf;
            st.prev      <= 4'h0;
            st.dtr_n     <= 1'b1;              // RULE_01
            st.rts_n     <= 1'b1;              // RULE_01
            st.spare_n   <= 1'b1;              // RULE_02
            st.int_oe_n  <= 1'b1;              // RULE_02
            st.txl       <= 1'b1;
            st.baud_en   <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign o_rdata          = st.rdata;
    assign o_dtr_n          = st.dtr_n;
    assign o_rts_n          = st.rts_n;
    assign o_spare_output_n = st.spare_n;
    assign o_int_oe_n       = st.int_oe_n;
    assign o_modem_irq      = st.irq;
    assign o_loopback       = st.modem_control[MC_LOOP];
    assign o_irda_sel       = st.modem_control[MC_IRDA];
    assign o_tx_line        = st.txl;
    assign o_baud_en        = st.baud_en;
    assign o_fifo_push      = st.push;
    assign o_tx_resume      = st.resume;
    assign o_tx_halt        = st.halt;
    assign o_mode_select    = st.enhanced_mode_select;

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    a_ready_pin_follows: assert property ( // RULE_01
        (i_wr && i_addr == ADDR_MODEM_CONTROL) |=> (o_dtr_n == !$past(i_wdata[0])))
        else $error("terminal-ready pin does not follow control bit 0");
    a_spare_int_enable: assert property ( // RULE_02
        (i_wr && i_addr == ADDR_MODEM_CONTROL) |=>
        ((o_spare_output_n == !$past(i_wdata[MC_INT_EN])) &&
         (o_int_oe_n == !$past(i_wdata[MC_INT_EN]))))
        else $error("spare output or interrupt enable does not follow bit 3");
    a_scratch_swap_write: assert property ( // RULE_22
        (i_wr && i_addr == ADDR_SCRATCH && st.feature_control[FC_SWAP]) |=> $stable(st.scr))
        else $error("scratch changed during swap write");
    a_overrun_no_push: assert property ( // RULE_10
        (i_rx_done && i_rx_fifo_full) |=> (!o_fifo_push && st.overrun))
        else $error("overrun did not block store");
    a_break_once: assert property ( // RULE_12
        (i_rx_done && i_rx_break && !i_rx_fifo_full) ##1 !i_rx_done ##1 (i_rx_done && i_rx_break)
        |=> !o_fifo_push)
        else $error("second break character stored");
    a_ring_rise_only: assert property ( // RULE_17
        (!st.delta[2] && !rd_msr && !(st.prev[2] && !eff_lvl[2])) |=> !st.delta[2])
        else $error("ring delta set without trailing edge");
    a_msr_read_clear: assert property ( // RULE_24
        (rd_msr && eff_lvl == st.prev) |=> (st.delta == 4'h0))
        else $error("delta bits not cleared by read");
    a_prescale_rate: assert property ( // RULE_08
        (st.modem_control[MC_PRESCALE] && o_baud_en) |=> (!o_baud_en || !st.modem_control[MC_PRESCALE]))
        else $error("divide-by-four enable too frequent");
    a_loop_status: assert property ( // RULE_20
        (rd_msr && st.modem_control[MC_LOOP]) |=> (o_rdata[7:4] == {$past(st.modem_control[3]), $past(st.modem_control[2]),
                                         $past(st.modem_control[0]), $past(st.modem_control[1])}))
        else $error("loopback status nibble wrong");

endmodule : mls_modem_line_status

//--- hdl/mls_pkg.sv
/*
 * Constants for the modem-control, line-status, modem-status and scratch
 * logic of one serial channel. Assumes a 40 MHz register clock and a plain
 * address/strobe register port driven by a host on the same clock.
 */
// Operation
// RULE_01: Control bits 0,1 drive ready/request lines low
// RULE_02: Control bit 3 enables interrupt, lowers spare
// RULE_03: Host keeps bit 3 zero on alternate bus
// RULE_04: Control bit 4 selects local loopback
// RULE_05: Xon-any: any received character resumes transmitter
// RULE_06: Xon-any stores characters except flow-control ones
// RULE_07: Control bit 6 selects infrared, idle low
// RULE_08: Control bit 7 divides baud clock by four
// RULE_09: Status bit 0 shows receive data present
// RULE_10: Full FIFO: overrun set, character dropped
// RULE_11: Parity/framing tags follow the holding character
// RULE_12: Break sets flag, stores one break character
// RULE_13: Holding-empty flag follows empty transmit FIFO
// RULE_14: Idle flag needs FIFO and shifter empty
// RULE_15: Bit 7 ORs error tags across FIFO
// RULE_16: Modem input changes set delta bits, interrupt
// RULE_17: Ring delta only on low-to-high input
// RULE_18: Auto clear-to-send halts transmitter when high
// RULE_19: Status high nibble shows inverted modem inputs
// RULE_20: Loopback high nibble shows control bits
// RULE_21: Scratch resets to all ones
// RULE_22: Swap sends scratch writes to mode select
// RULE_23: Swap makes scratch reads return FIFO level
// RULE_24: Reading modem status clears delta bits
// RULE_25: Reading line status clears overrun, break
package mls_pkg;
    // Register indices on the 3-bit register port
    localparam logic [2:0] ADDR_INT_ENABLE    = 3'h1;
    localparam logic [2:0] ADDR_FEATURE_CTRL  = 3'h2;
    localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_LINE_STATUS   = 3'h5;
    localparam logic [2:0] ADDR_MODEM_STATUS  = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH       = 3'h7;
    // Modem control field positions
    localparam int MC_READY    = 0;
    localparam int MC_REQUEST  = 1;
    localparam int MC_SPARE1   = 2;
    localparam int MC_INT_EN   = 3;
    localparam int MC_LOOP     = 4;
    localparam int MC_XON_ANY  = 5;
    localparam int MC_IRDA     = 6;
    localparam int MC_PRESCALE = 7;
    // Other field positions
    localparam int IE_MODEM    = 3;
    localparam int FC_SWAP     = 6;
    // Values after reset
    localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
    localparam logic [7:0] SCRATCH_RST       = 8'hff;
    localparam logic [7:0] INT_ENABLE_RST    = 8'h00;
    localparam logic [7:0] FEATURE_CTRL_RST  = 8'h00;
    localparam logic [7:0] MODE_SELECT_RST   = 8'h00;
    // Last prescaler count when divide-by-four is chosen
    localparam logic [1:0] PRESCALE_LAST     = 2'h3;
    // Depth of receive FIFO
    localparam int         RX_FIFO_DEPTH     = 64;
endpackage : mls_pkg

//--- dv/mls_modem_peer.sv
/*
 * Modem peer on the handshake pins of one serial channel.
 * Assumes the bench sets ring/carrier levels and the answer delay.
 */
module mls_modem_peer
(
    input  wire logic       i_ref_clk, // Shared clock
    input  wire logic       i_dtr_n,   // Terminal ready from block
    input  wire logic       i_rts_n,   // Request to send from block
    input  wire logic       i_ring_n,  // Ring level wanted by bench
    input  wire logic       i_cd_n,    // Carrier level wanted by bench
    input  wire logic [3:0] i_lag,     // Answer delay in cycles
    output logic            o_cts_n,   // Clear to send answer
    output logic            o_dsr_n,   // Data set ready answer
    output logic            o_ri_n,    // Ring pin
    output logic            o_cd_n     // Carrier pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_cnt = 4'h0; // Cycles left before answering
    initial
    begin
        {o_cts_n, o_dsr_n, o_ri_n, o_cd_n} = 4'hf;
    end
    // Answers follow the requests after the set delay
    always @(posedge i_ref_clk)
    begin
        o_ri_n <= i_ring_n;
        o_cd_n <= i_cd_n;
        if ({o_cts_n, o_dsr_n} == {i_rts_n, i_dtr_n})
            wait_cnt <= i_lag;
        else if (wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
        else
        begin
            o_cts_n <= i_rts_n;
            o_dsr_n <= i_dtr_n;
        end
    end
endmodule : mls_modem_peer

//--- dv/tb_uart_modem_line_status.sv
/*
 * Self-checking bench for the modem and line status registers.
 * Assumes a modem peer on the handshake pins and a 40 MHz clock.
 */
module tb_uart_modem_line_status
    import mls_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, rst, wr, rd, rx_done, rx_par, rx_frm, rx_brk, rx_flow;
    logic       sw_flow, fifo_full, rhr_load, rhr_read, tx_empty, tsr_empty;
    logic       auto_cts, ring_n, cd_n, cts_n, dsr_n, ri_n, cdp_n, dtr_n, rts_n;
    logic       spare_n, int_oe_n, irq, loop, irda, tx_line, baud_en, push, resume, halt;
    logic [2:0] addr, rhr_tags;
    logic [3:0] lag;
    logic [6:0] fifo_cnt;
    logic [7:0] wdata, rdata, fifo_lvl, mode_sel, v;
    int         bad_count, cmp_count, cycles, n;
    // Control values; the plain bus is modelled, so bit 3 may be set
    logic [7:0] ctl_tab [7] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h40, 8'h5b, 8'h00};

    mls_modem_line_status DUT (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cts_n(cts_n),
        .i_dsr_n(dsr_n), .i_ring_indicate_in_n(ri_n), .i_carrier_detect_in_n(cdp_n),
        .o_dtr_n(dtr_n), .o_rts_n(rts_n), .o_spare_output_n(spare_n),
        .o_int_oe_n(int_oe_n), .o_modem_irq(irq), .o_loopback(loop), .o_irda_sel(irda),
        .i_tx_serial(1'b1), .i_tx_ir(1'b0), .o_tx_line(tx_line), .o_baud_en(baud_en),
        .i_rx_done(rx_done), .i_rx_parity_err(rx_par), .i_rx_frame_err(rx_frm),
        .i_rx_break(rx_brk), .i_rx_flow_char(rx_flow), .i_sw_flow_on(sw_flow),
        .i_rx_fifo_full(fifo_full), .i_rx_fifo_count(fifo_cnt), .i_rhr_load(rhr_load),
        .i_rhr_tags(rhr_tags), .i_rhr_read(rhr_read), .i_tx_fifo_empty(tx_empty),
        .i_tsr_empty(tsr_empty), .i_auto_cts_en(auto_cts), .i_fifo_level(fifo_lvl),
        .o_fifo_push(push), .o_tx_resume(resume), .o_tx_halt(halt),
        .o_mode_select(mode_sel));
    mls_modem_peer PEER (.i_ref_clk(clk), .i_dtr_n(dtr_n), .i_rts_n(rts_n),
        .i_ring_n(ring_n), .i_cd_n(cd_n), .i_lag(lag), .o_cts_n(cts_n),
        .o_dsr_n(dsr_n), .o_ri_n(ri_n), .o_cd_n(cdp_n));

    // Clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // One-cycle register write
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // Read, data taken in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        chk(v, exp, what);
    endtask : rreg
    // Received character, f = {flow, break, frame, parity}
    task automatic rx(input logic [3:0] f, input logic [1:0] exp);
        @(posedge clk);
        rx_done <= 1'b1;
        {rx_flow, rx_brk, rx_frm, rx_par} <= f;
        @(posedge clk);
        rx_done <= 1'b0;
        #1 chk({6'h0, push, resume}, {6'h0, exp}, "push/resume");
    endtask : rx
    // Holding register load (ld=1) or host read (ld=0)
    task automatic hold(input logic ld, input logic [2:0] t);
        @(posedge clk);
        rhr_load <= ld;
        rhr_read <= !ld;
        rhr_tags <= t;
        @(posedge clk);
        rhr_load <= 1'b0;
        rhr_read <= 1'b0;
    endtask : hold

    task automatic t_reset();
        tick(1);
        chk({dtr_n, rts_n, spare_n, int_oe_n, baud_en, loop, irda, halt}, 8'hf8, "pins");
        rreg(ADDR_MODEM_CONTROL, 8'h00, "control");
        rreg(ADDR_SCRATCH, 8'hff, "scratch");
        rreg(3'h0, 8'h00, "unmapped");
        wreg(ADDR_SCRATCH, 8'h5a);
        rreg(ADDR_SCRATCH, 8'h5a, "scratch");
    endtask : t_reset
    task automatic t_control();
        foreach (ctl_tab[i])
        begin
            wreg(ADDR_MODEM_CONTROL, ctl_tab[i]);
            tick(2);
            v = ctl_tab[i];
            chk({1'b0, dtr_n, rts_n, spare_n, int_oe_n, loop, irda, tx_line}, {1'b0, ~v[0], ~v[1], ~v[3], ~v[3], v[4], v[6], v[4] | ~v[6]}, "pins");
            rreg(ADDR_MODEM_CONTROL, ctl_tab[i], "control");
        end
        for (int p = 0; p < 2; p++)
        begin
            wreg(ADDR_MODEM_CONTROL, p ? 8'h00 : 8'h80);
            tick(2);
            n = 0;
            repeat (8) begin @(posedge clk); #1 n += baud_en; end
            chk(8'(n), p ? 8'h08 : 8'h02, "baud enables");
        end
    endtask : t_control
    task automatic t_status();
        rreg(ADDR_LINE_STATUS, 8'h60, "idle tx");
        fifo_cnt <= 7'h05;
        tsr_empty <= 1'b0;
        wreg(ADDR_LINE_STATUS, 8'hff);
        rreg(ADDR_LINE_STATUS, 8'h21, "shifting");
        tx_empty <= 1'b0;
        fifo_full <= 1'b1;
        rx(4'h0, 2'b00);
        fifo_full <= 1'b0;
        rreg(ADDR_LINE_STATUS, 8'h03, "overrun");
        rreg(ADDR_LINE_STATUS, 8'h01, "overrun clear");
        rx(4'h4, 2'b10);
        rx(4'h4, 2'b00);
        rx(4'h0, 2'b10);
        rreg(ADDR_LINE_STATUS, 8'h91, "break");
        rreg(ADDR_LINE_STATUS, 8'h81, "break clear");
        hold(1'b1, 3'h4);
        rreg(ADDR_LINE_STATUS, 8'h91, "break tag");
        hold(1'b0, 3'h0);
        hold(1'b1, 3'h0);
        rreg(ADDR_LINE_STATUS, 8'h01, "no errors");
        rx(4'h1, 2'b10);
        hold(1'b1, 3'h3);
        rreg(ADDR_LINE_STATUS, 8'h8d, "parity frame");
        wreg(ADDR_MODEM_CONTROL, 8'h20);
        sw_flow <= 1'b1;
        rx(4'h8, 2'b01);
        rx(4'h0, 2'b11);
        sw_flow <= 1'b0;
    endtask : t_status
    task automatic t_modem();
        wreg(ADDR_MODEM_CONTROL, 8'h00);
        wreg(ADDR_INT_ENABLE, 8'h08);
        rreg(ADDR_INT_ENABLE, 8'h08, "int enable");
        tick(8);
        // Deltas left over from the control sweep: cts, dsr, carrier
        rreg(ADDR_MODEM_STATUS, 8'h0b, "leftover deltas");
        wreg(ADDR_MODEM_CONTROL, 8'h02);
        tick(8);
        chk({7'h0, irq}, 8'h01, "irq");
        rreg(ADDR_MODEM_STATUS, 8'h11, "cts");
        tick(2);
        chk({7'h0, irq}, 8'h00, "irq cleared");
        ring_n <= 1'b0;
        tick(8);
        rreg(ADDR_MODEM_STATUS, 8'h50, "ring start");
        ring_n <= 1'b1;
        cd_n <= 1'b0;
        tick(8);
        rreg(ADDR_MODEM_STATUS, 8'h9c, "ring end");
        lag <= 4'h6;
        wreg(ADDR_MODEM_CONTROL, 8'h03);
        tick(3);
        rreg(ADDR_MODEM_STATUS, 8'h90, "dsr early");
        tick(12);
        rreg(ADDR_MODEM_STATUS, 8'hb2, "dsr");
        wreg(ADDR_MODEM_CONTROL, 8'h1d);
        tick(4);
        rreg(ADDR_MODEM_STATUS, 8'he1, "loop");
        chk(v & 8'hf0, 8'he0, "loop nibble");
        chk({7'h0, tx_line}, 8'h01, "loop line");
        lag <= 4'h0;
        auto_cts <= 1'b1;
        wreg(ADDR_MODEM_CONTROL, 8'h00);
        tick(10);
        chk({7'h0, halt}, 8'h01, "halt");
        wreg(ADDR_MODEM_CONTROL, 8'h02);
        tick(10);
        chk({7'h0, halt}, 8'h00, "resume");
    endtask : t_modem
    task automatic t_swap();
        wreg(ADDR_FEATURE_CTRL, 8'h40);
        rreg(ADDR_FEATURE_CTRL, 8'h40, "feature");
        wreg(ADDR_SCRATCH, 8'h3c);
        tick(2);
        chk(mode_sel, 8'h3c, "mode select");
        rreg(ADDR_SCRATCH, 8'h27, "level");
        wreg(ADDR_FEATURE_CTRL, 8'h00);
        rreg(ADDR_SCRATCH, 8'h5a, "scratch kept");
    endtask : t_swap

    task automatic end_sim();
        $display("Checks: %0d, mismatches: %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Main sequence
    initial
    begin
        {wr, rd, rx_done, rx_par, rx_frm, rx_brk, rx_flow, sw_flow} = 8'h00;
        {fifo_full, rhr_load, rhr_read, auto_cts, addr, rhr_tags} = 10'h000;
        {tx_empty, tsr_empty, ring_n, cd_n, rst} = 5'h1f;
        {fifo_cnt, wdata, lag, fifo_lvl} = 27'h0000027;
        bad_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_control();
        t_status();
        t_modem();
        t_swap();
        end_sim();
    end
endmodule : tb_uart_modem_line_status
